// ===== hrbp_pkg.sv
// package for the host-side parallel register port controller
// assumes a single 200 MHz clock domain
`default_nettype none
package hrbp_pkg;
	localparam int HRBP_ADDR_W = 13;
	localparam int HRBP_DATA_W = 8;
	// clock period and strobe timing, ns
	localparam int HRBP_CLK_PERIOD_NS = 5;
	localparam int HRBP_SETUP_NS = 20;
	localparam int HRBP_STROBE_NS = 100;
	localparam int HRBP_HOLD_NS = 20;
	localparam int HRBP_SETUP_CYC = (HRBP_SETUP_NS + HRBP_CLK_PERIOD_NS - 1) / HRBP_CLK_PERIOD_NS;
	localparam int HRBP_STROBE_CYC = (HRBP_STROBE_NS + HRBP_CLK_PERIOD_NS - 1) / HRBP_CLK_PERIOD_NS;
	localparam int HRBP_HOLD_CYC = (HRBP_HOLD_NS + HRBP_CLK_PERIOD_NS - 1) / HRBP_CLK_PERIOD_NS;
	localparam int HRBP_CNT_W = 8;

	typedef struct packed {
		logic write;
		logic [HRBP_ADDR_W-1:0] addr;
		logic [HRBP_DATA_W-1:0] wdata;
	} hrbp_req_s;

	typedef struct packed {
		logic chip_select_n;
		logic read_or_data_strobe_n;
		logic write_or_dir_select_n;
		logic [HRBP_ADDR_W-1:0] addr;
	} hrbp_pins_s;

	typedef enum logic [1:0] {
		HRBP_IDLE,
		HRBP_SETUP,
		HRBP_STROBE,
		HRBP_HOLD
	} hrbp_state_e;
endpackage
`default_nettype wire

// ===== hrbp_host.sv
// host controller that drives the device's parallel register port
// assumes device pins are resolved by the bench; data bus split in/out/oe
`default_nettype none
// Overview of operation
// - host places a 13-bit register address on the address pins each access
// - address msb on top pin, lsb on pin zero
// - data travels on one 8-bit bidirectional bus, msb on bit seven
// - host reads by driving read strobe and chip select low
module hrbp_host #(
	parameter int SETUP_CYC = hrbp_pkg::HRBP_SETUP_CYC,
	parameter int STROBE_CYC = hrbp_pkg::HRBP_STROBE_CYC,
	parameter int HOLD_CYC = hrbp_pkg::HRBP_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic bus_style_select_i,
	input wire logic req_valid_i,
	input wire hrbp_pkg::hrbp_req_s req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [hrbp_pkg::HRBP_DATA_W-1:0] rsp_rdata_o,
	output var hrbp_pkg::hrbp_pins_s pins_o,
	output logic [hrbp_pkg::HRBP_DATA_W-1:0] data_o,
	output logic data_oe_o,
	input wire logic [hrbp_pkg::HRBP_DATA_W-1:0] data_i,
	input wire logic irq_out_n_i,
	output logic irq_pending_o
);
	import hrbp_pkg::*;

	// counts must fit the counter, with at least two strobe cycles and one each of setup and hold
	if (SETUP_CYC < 1 || STROBE_CYC < 2 || HOLD_CYC < 1 || STROBE_CYC > 255 || SETUP_CYC > 255
		|| HOLD_CYC > 255) begin : g_bad_timing
		$error("hrbp_host: timing counts out of range");
	end

	localparam logic [HRBP_CNT_W-1:0] SETUP_LAST = HRBP_CNT_W'(SETUP_CYC - 1);
	localparam logic [HRBP_CNT_W-1:0] STROBE_LAST = HRBP_CNT_W'(STROBE_CYC - 1);
	localparam logic [HRBP_CNT_W-1:0] HOLD_LAST = HRBP_CNT_W'(HOLD_CYC - 1);
	localparam logic [HRBP_CNT_W-1:0] CNT_ZERO = '0;

	// ==========================================================
	// synchronisers
	logic [HRBP_DATA_W-1:0] data_s1_reg, data_s2_reg;
	logic irq_s1_reg, irq_s2_reg;
	logic style_s1_reg, style_s2_reg;

	always_ff @(posedge sys_clk_i) begin
		data_s1_reg <= data_i;
		data_s2_reg <= data_s1_reg;
		irq_s1_reg <= irq_out_n_i;
		irq_s2_reg <= irq_s1_reg;
		style_s1_reg <= bus_style_select_i;
		style_s2_reg <= style_s1_reg;
	end

	// ==========================================================
	// access sequencer
	hrbp_state_e state_reg;
	logic [HRBP_CNT_W-1:0] cnt_reg;
	hrbp_req_s cur_reg;
	logic style_reg;

	function automatic logic cnt_done(input logic [HRBP_CNT_W-1:0] c, input logic [HRBP_CNT_W-1:0] last);
		cnt_done = (c == last);
	endfunction

	assign req_ready_o = (state_reg == HRBP_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			state_reg <= HRBP_IDLE;
			cnt_reg <= CNT_ZERO;
			cur_reg <= '0;
			style_reg <= 1'b0;
		end else begin
			case (state_reg)
				HRBP_IDLE: begin
					cnt_reg <= CNT_ZERO;
					if (req_valid_i) begin
						cur_reg <= req_i;
						style_reg <= style_s2_reg;
						state_reg <= HRBP_SETUP;
					end
				end
				HRBP_SETUP: begin
					cnt_reg <= cnt_done(cnt_reg, SETUP_LAST) ? CNT_ZERO : cnt_reg + 1'b1;
					if (cnt_done(cnt_reg, SETUP_LAST)) state_reg <= HRBP_STROBE;
				end
				HRBP_STROBE: begin
					cnt_reg <= cnt_done(cnt_reg, STROBE_LAST) ? CNT_ZERO : cnt_reg + 1'b1;
					if (cnt_done(cnt_reg, STROBE_LAST)) state_reg <= HRBP_HOLD;
				end
				HRBP_HOLD: begin
					cnt_reg <= cnt_done(cnt_reg, HOLD_LAST) ? CNT_ZERO : cnt_reg + 1'b1;
					if (cnt_done(cnt_reg, HOLD_LAST)) state_reg <= HRBP_IDLE;
				end
				default: state_reg <= HRBP_IDLE;
			endcase
		end
	end

	// ==========================================================
	// pin drive
	logic strobe_on;
	assign strobe_on = (state_reg == HRBP_STROBE);

	function automatic logic next_strobe();
		next_strobe = (state_reg == HRBP_SETUP && cnt_done(cnt_reg, SETUP_LAST)) ||
			(state_reg == HRBP_STROBE && !cnt_done(cnt_reg, STROBE_LAST));
	endfunction

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			pins_o <= '{chip_select_n: 1'b1, read_or_data_strobe_n: 1'b1, write_or_dir_select_n: 1'b1,
				addr: '0};
		end else begin
			pins_o.addr <= (state_reg == HRBP_IDLE && req_valid_i) ? req_i.addr : pins_o.addr;
			pins_o.chip_select_n <= !((state_reg == HRBP_IDLE && req_valid_i) ||
				(state_reg == HRBP_SETUP) || (state_reg == HRBP_STROBE) ||
				(state_reg == HRBP_HOLD && !cnt_done(cnt_reg, HOLD_LAST)));
			if (style_reg) begin
				// data strobe plus direction: direction low means write, set up before strobe
				pins_o.read_or_data_strobe_n <= !(next_strobe());
				pins_o.write_or_dir_select_n <= (state_reg == HRBP_IDLE) ? !(req_valid_i && req_i.write) :
					!cur_reg.write;
			end else begin
				pins_o.read_or_data_strobe_n <= !(next_strobe() && !cur_reg.write);
				pins_o.write_or_dir_select_n <= !(next_strobe() && cur_reg.write);
			end
		end
	end

	// write data driven across the whole write access; floats otherwise
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			data_o <= '0;
			data_oe_o <= 1'b0;
		end else begin
			if (state_reg == HRBP_IDLE && req_valid_i) data_o <= req_i.wdata;
			data_oe_o <= (state_reg == HRBP_IDLE) ? (req_valid_i && req_i.write) :
				(cur_reg.write && !(state_reg == HRBP_HOLD && cnt_done(cnt_reg, HOLD_LAST)));
		end
	end

	// ==========================================================
	// read capture and response
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= '0;
		end else begin
			rsp_valid_o <= (state_reg == HRBP_STROBE) && cnt_done(cnt_reg, STROBE_LAST);
			if (state_reg == HRBP_STROBE && cnt_done(cnt_reg, STROBE_LAST) && !cur_reg.write)
				rsp_rdata_o <= data_s2_reg;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) irq_pending_o <= 1'b0;
		else irq_pending_o <= !irq_s2_reg;
	end

	// ==========================================================
	// checks
	property p_strobe_needs_cs;
		@(posedge sys_clk_i) disable iff (!rst_b_i) !pins_o.read_or_data_strobe_n |-> !pins_o.chip_select_n;
	endproperty
	a_strobe_needs_cs: assert property (p_strobe_needs_cs)
		else $error("strobe low without chip select");

	property p_wr_strobe_needs_cs;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
			(!style_reg && !pins_o.write_or_dir_select_n) |-> !pins_o.chip_select_n;
	endproperty
	a_wr_strobe_needs_cs: assert property (p_wr_strobe_needs_cs)
		else $error("write strobe low without chip select");

	property p_no_drive_read;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
			(!pins_o.chip_select_n && !cur_reg.write && state_reg != HRBP_IDLE) |-> !data_oe_o;
	endproperty
	a_no_drive_read: assert property (p_no_drive_read)
		else $error("host drives bus during read");

	property p_rsp_after_strobe;
		@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(rsp_valid_o) |-> $past(state_reg) == HRBP_STROBE;
	endproperty
	a_rsp_after_strobe: assert property (p_rsp_after_strobe)
		else $error("response outside strobe end");

	property p_addr_stable;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
			(!pins_o.chip_select_n && !$past(pins_o.chip_select_n)) |-> $stable(pins_o.addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("address moved during access");

	property p_data_stable;
		@(posedge sys_clk_i) disable iff (!rst_b_i) (data_oe_o && $past(data_oe_o)) |-> $stable(data_o);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("write data moved during access");

	property p_single_strobe;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
			!style_reg |-> (pins_o.read_or_data_strobe_n || pins_o.write_or_dir_select_n);
	endproperty
	a_single_strobe: assert property (p_single_strobe)
		else $error("both strobes low");

	property p_irq_follow;
		@(posedge sys_clk_i) disable iff (!rst_b_i) !irq_s2_reg |=> irq_pending_o;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("interrupt not reported");

	c_read: cover property (@(posedge sys_clk_i) rsp_valid_o && !cur_reg.write);
	c_style_write: cover property (@(posedge sys_clk_i) style_reg && strobe_on && cur_reg.write);
	c_write: cover property (@(posedge sys_clk_i) rsp_valid_o && cur_reg.write);
	c_style: cover property (@(posedge sys_clk_i) style_reg && !pins_o.read_or_data_strobe_n);
	c_irq: cover property (@(posedge sys_clk_i) irq_pending_o);
endmodule
`default_nettype wire

// ===== hrbp_dev_model.sv
// model of the device's parallel register port
// assumes host pins as driven by hrbp_host; bench resolves the data bus
`default_nettype none
module hrbp_dev_model import hrbp_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic style_i,
	input wire hrbp_pkg::hrbp_pins_s pins_i,
	input wire logic [7:0] data_i,
	input wire logic [3:0] src_i,
	input wire logic [3:0] mask_i,
	output logic [7:0] data_o,
	output logic oe_o,
	output logic irq_out_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:8191];
	logic rd, wr, wr_q;
	logic [12:0] a_q;
	logic [7:0] d_q;
	initial begin
		for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5A;
	end
	// strap picks strobe meaning, all gated by select
	assign rd = !pins_i.chip_select_n && !pins_i.read_or_data_strobe_n
		&& (!style_i || pins_i.write_or_dir_select_n);
	assign wr = !pins_i.chip_select_n && !pins_i.write_or_dir_select_n
		&& (!style_i || !pins_i.read_or_data_strobe_n);
	assign oe_o = rd;
	assign data_o = mem[pins_i.addr];
	assign irq_out_n_o = !(|(src_i & ~mask_i));
	always @(posedge sys_clk_i) begin
		wr_q <= wr;
		a_q <= pins_i.addr;
		d_q <= data_i;
		if (wr_q && !wr) mem[a_q] <= d_q;
	end
endmodule
`default_nettype wire

// ===== hrbp_host_test.sv
// self-checking bench for hrbp_host against the device model
// assumes hrbp_pkg and hrbp_dev_model are compiled first
`default_nettype none
module hrbp_host_test;
	import hrbp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 0, rst_b_i = 0, style = 0, req_valid = 0, rsp_valid, ready, oe, dev_oe, irq_n, irq_p;
	logic [7:0] q, rdata, dout, dev_d, bus;
	logic [3:0] src = 0, mask = 0;
	logic [31:0] seed = 32'hE74B19AE;
	hrbp_req_s req = '0;
	hrbp_pins_s pins;
	int error_cnt = 0, check_count = 0;
	logic [7:0] ref_mem [int];
	logic [12:0] aq [$];
	localparam int SETUP_CYC_T = HRBP_SETUP_CYC + HRBP_STROBE_CYC + 1;
	// floating bus shows the inverse of the device value
	assign bus = dev_oe ? dev_d : (oe ? dout : ~dev_d);
	hrbp_host dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_style_select_i(style), .req_valid_i(req_valid),
		.req_i(req), .req_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata), .pins_o(pins),
		.data_o(dout), .data_oe_o(oe), .data_i(bus), .irq_out_n_i(irq_n), .irq_pending_o(irq_p));
	hrbp_dev_model dev_u (.sys_clk_i(sys_clk_i), .style_i(style), .pins_i(pins), .data_i(bus), .src_i(src),
		.mask_i(mask), .data_o(dev_d), .oe_o(dev_oe), .irq_out_n_o(irq_n));
	initial begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic access(input logic wr, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check("ready", 8'(ready), 8'h01);
		check("idle select", 8'(pins.chip_select_n), 8'h01);
		req = '{wr, a, d};
		req_valid = 1;
		@(posedge sys_clk_i);
		#1;
		req_valid = 0;
		n = 1;
		while (rsp_valid !== 1'b1 && n < 200) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check("latency", 8'(n), 8'(SETUP_CYC_T));
		q = rdata;
		if (wr) ref_mem[a] = d;
	endtask
	task automatic read_check(input logic [12:0] a);
		access(0, a, 8'h00);
		check("read data", q, ref_mem.exists(a) ? ref_mem[a] : 8'(a) ^ 8'h5A);
	endtask
	// fixed wait past the three-stage path, so a level that should stay is really held
	task automatic irq_check(input logic exp);
		repeat (5) @(posedge sys_clk_i);
		#1;
		check("irq pending", 8'(irq_p), 8'(exp));
	endtask
	always @(posedge sys_clk_i) begin
		if (dev_oe === 1'b1 && oe === 1'b1) check("bus contention", 8'h01, 8'h00);
	end
	initial begin
		#50000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		#1;
		rst_b_i = 1;
		for (int s = 0; s < 2; s++) begin
			style = 1'(s);
			repeat (4) @(posedge sys_clk_i);
			#1;
			read_check(13'h0001);
			read_check(13'h1000);
			for (int i = 0; i < 10; i++) begin
				aq.push_back(i == 0 ? 13'h1FFF : 13'(rnd()));
				access(1, aq[$], 8'(rnd()));
			end
			while (aq.size() > 0) read_check(aq.pop_front());
		end
		for (int k = 0; k < 4; k++) begin
			src = 4'(1 << k);
			irq_check(1);
			mask = src;
			irq_check(0);
			mask = 0;
			src = 4'hF;
			irq_check(1);
			src = src & ~4'(1 << k);
			irq_check(1);
			src = 0;
			irq_check(0);
		end
		complete_run();
	end
endmodule
`default_nettype wire
